/* rtc_sync_pkg.sv */
// Function
// R01: Stamp every input sample within one millisecond
// R02: Align clock to external code or network
// R03: Event time is the change's sampling instant
// R04: Same interval: unfiltered event, then filtered event
// R05: Peer status published on time, never delayed
// R06: Minute sync taken from one routed input
// R07: Sync pulse within window steps to minute
// R08: Seconds 00-29 round down, 30-59 up
// R09: Within window, slew slower or faster instead
// R10: Source sends ~20 ms pulses, once a minute
// R11: Per-input event mask suppresses chosen inputs
// R12: Per-input filter enable; zero bypasses filter
// R13: Slew at fixed rate, never backwards
package rtc_sync_pkg;
  // Clock and millisecond tick
  localparam int CLK_PERIOD_NS  = 100;
  localparam int MS_NS          = 1000000;
  localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  // Input count and time fields
  localparam int NIN_DEF     = 16;
  localparam int MS_W        = 16;
  localparam int MIN_W       = 11;
  localparam int STAMP_W     = MS_W + MIN_W;
  localparam int MS_PER_MIN  = 60000;
  localparam int MIN_PER_DAY = 1440;
  localparam int HALF_MIN_MS = 30000;
  // Sync window, filter, slew and publish periods in ms
  localparam int SYNC_WIN_MS = 3000;
  localparam int FILT_MS     = 10;
  localparam int SLEW_DIV_MS = 10;
  localparam int PUB_MS      = 100;
  // Internal signal bus number of the sync signal
  localparam logic [7:0] SYNC_SIG_ID = 8'h74;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_FILTEN = 8'h04;
  localparam logic [7:0] ADR_EVMASK = 8'h08;
  localparam logic [7:0] ADR_SYNC   = 8'h0C;
  localparam logic [7:0] ADR_TIME   = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_IMASK  = 8'h18;
  localparam logic [7:0] ADR_INPUTS = 8'h1C;
  // Field positions
  localparam int CTRL_SLEW_BIT = 0;
  localparam int TIME_MIN_LSB  = 16;
  localparam int SYNC_ID_LSB   = 24;
  localparam int ST_UNF  = 0;
  localparam int ST_FLT  = 1;
  localparam int ST_STEP = 2;
  localparam int ST_SLEW = 3;
  localparam int ST_REJ  = 4;
  localparam int ST_W    = 5;
  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam logic [31:0] FILTEN_RST = 32'h0000_FFFF;
  localparam logic [31:0] EVMASK_RST = 32'h0000_FFFF;
  localparam logic [3:0]  SEL_RST    = 4'h0;
  localparam logic [4:0]  IMASK_RST  = 5'h00;
endpackage

/* input_conditioner.sv */
module input_conditioner #(
  parameter int NIN    = 16,
  parameter int FILT_N = 10
) (
  input  wire logic           sys_clk,
  input  wire logic           nrst,
  input  wire logic           sampleEn,
  input  wire logic [NIN-1:0] pinIn,
  output logic      [NIN-1:0] sampS,
  output logic      [NIN-1:0] filtS
);
  localparam int CW = $clog2(FILT_N + 1);

  logic [NIN-1:0] meta1Q;  // First stage, read only by second
  logic [NIN-1:0] meta2Q;  // Synchronised pin level

  // Two-flop synchroniser
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta1Q <= '0;
      meta2Q <= '0;
    end else begin
      meta1Q <= pinIn;
      meta2Q <= meta1Q;
    end
  end

  // Raw sample at each ms tick
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sampS <= '0;
    end else if (sampleEn) begin
      sampS <= meta2Q;
    end
  end

  // Per-input filter: FILT_N equal differing samples accept
  for (genvar i = 0; i < NIN; i++) begin : g_filt
    logic [CW-1:0] cntQ;  // Consecutive differing samples
    logic          fltQ;  // Accepted level
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        cntQ <= '0;
        fltQ <= 1'b0;
      end else if (sampleEn) begin
        if (meta2Q[i] == fltQ) begin
          cntQ <= '0;
        end else if (cntQ == CW'(FILT_N - 1)) begin
          fltQ <= meta2Q[i];
          cntQ <= '0;
        end else begin
          cntQ <= cntQ + CW'(1);
        end
      end
    end
    assign filtS[i] = fltQ;
  end
endmodule

/* rtc_timestamp_sync.sv */
// The implementer's own choices: the register offsets and the Wishbone register port.
module rtc_timestamp_sync #(
  parameter int CYC_PER_MS = rtc_sync_pkg::CYC_PER_MS_DEF,
  parameter int NIN        = rtc_sync_pkg::NIN_DEF
) (
  input  wire logic                             sys_clk,
  input  wire logic                             nrst,
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [7:0]                       wb_adr_i,
  input  wire logic [31:0]                      wb_dat_i,
  output logic      [31:0]                      wb_dat_o,
  output logic                                  wb_ack_o,
  input  wire logic [NIN-1:0]                   optoPin,
  output logic                                  irq,
  output logic                                  evValid,
  output logic                                  evFiltered,
  output logic      [NIN-1:0]                   evMask,
  output logic      [NIN-1:0]                   evState,
  output logic      [rtc_sync_pkg::STAMP_W-1:0] evStamp,
  output logic                                  pubValid,
  output logic      [NIN-1:0]                   pubState
);
  import rtc_sync_pkg::*;

  localparam int DIV_W = $clog2(CYC_PER_MS);
  localparam int SEL_W = $clog2(NIN);

  // Advance time by inc ms, wrapping minute and day
  function automatic logic [STAMP_W-1:0] advance(
      input logic [MIN_W-1:0] mn, input logic [MS_W-1:0] ms,
      input logic [1:0] inc);
    logic [MS_W:0]    s;
    logic [MIN_W-1:0] m;
    s = {1'b0, ms} + (MS_W+1)'(inc);
    m = mn;
    if (s >= (MS_W+1)'(MS_PER_MIN)) begin
      s = s - (MS_W+1)'(MS_PER_MIN);
      m = (mn == MIN_W'(MIN_PER_DAY-1)) ? '0 : mn + MIN_W'(1);
    end
    advance = {m, s[MS_W-1:0]};
  endfunction

  // Step a stamp back by d ms
  function automatic logic [STAMP_W-1:0] retreat(
      input logic [STAMP_W-1:0] t, input logic [MS_W-1:0] d);
    logic [MIN_W-1:0] m;
    logic [MS_W-1:0]  s;
    m = t[STAMP_W-1:MS_W];
    s = t[MS_W-1:0];
    if (s >= d) begin
      s = s - d;
    end else begin
      s = s + MS_W'(MS_PER_MIN) - d;
      m = (m == '0) ? MIN_W'(MIN_PER_DAY-1) : m - MIN_W'(1);
    end
    retreat = {m, s};
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(
      input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    merge = r;
  endfunction

  logic [DIV_W-1:0]   divQ;       // Cycle count inside one ms
  logic               tickQ;      // One-cycle ms sampling pulse
  logic               tickDQ;     // Samples visible
  logic [MS_W-1:0]    msQ;        // Ms within minute
  logic [MIN_W-1:0]   minQ;       // Minute of day
  logic [STAMP_W-1:0] stampQ;     // Time at last sampling instant
  logic [11:0]        slewRemQ;   // Ms still to correct
  logic               slewFastQ;  // Clock behind, run faster
  logic [3:0]         slewDivQ;   // Ticks between corrections
  logic [31:0]        ctrlQ;      // Control, bit 0 enables slewing
  logic [NIN-1:0]     filtEnQ;    // Per-input filter enables
  logic [NIN-1:0]     evMaskQ;    // Per-input event enables
  logic [SEL_W-1:0]   syncSelQ;   // Input routed to sync signal
  logic [ST_W-1:0]    statusQ;    // Sticky event flags
  logic [ST_W-1:0]    imaskQ;     // Interrupt enables
  logic [NIN-1:0]     sampS;      // Raw sampled inputs
  logic [NIN-1:0]     filtS;      // Filtered inputs
  logic [NIN-1:0]     sampPrevQ;  // Previous raw samples
  logic [NIN-1:0]     fltPrevQ;   // Previous filtered states
  logic               syncPrevQ;  // Previous sync level
  logic               fltPendQ;   // Filtered event waiting
  logic [NIN-1:0]     fltChgQ;    // Its changed inputs
  logic [NIN-1:0]     fltStateQ;  // Its states
  logic [STAMP_W-1:0] fltStampQ;  // Its stamp
  logic [6:0]         pubCntQ;    // Ticks since last publication
  logic [NIN-1:0]     condS;      // Inputs as the logic sees them
  logic [NIN-1:0]     unfChg;     // Masked unfiltered changes
  logic [NIN-1:0]     fltChg;     // Masked filtered changes
  logic [MS_W-1:0]    errMs;      // Distance to nearest minute
  logic               roundUp;    // Nearest minute is the next one
  logic               inWin;      // Within the sync window
  logic               syncRise;   // Sync pulse seen this cycle
  logic               slewAct;    // Apply one slew ms this tick
  logic [1:0]         incr;       // Ms added this tick
  logic               acc;        // Bus access taken this cycle
  logic               wrEn;       // Write taken
  logic               timeWr;     // Software time load

  input_conditioner #(.NIN(NIN), .FILT_N(FILT_MS)) u_cond (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .sampleEn (tickQ),
    .pinIn    (optoPin),
    .sampS    (sampS),
    .filtS    (filtS)
  );

  // R12: filter bypass select
  assign condS = (filtS & filtEnQ) | (sampS & ~filtEnQ);
  // R11: per-input event masking
  assign unfChg = (sampS ^ sampPrevQ) & ~filtEnQ & evMaskQ;
  assign fltChg = (filtS ^ fltPrevQ) & filtEnQ & evMaskQ;

  // R08: distance to the nearest minute
  assign roundUp = msQ >= MS_W'(HALF_MIN_MS);
  assign errMs   = roundUp ? MS_W'(MS_PER_MIN) - msQ : msQ;
  assign inWin   = errMs <= MS_W'(SYNC_WIN_MS);
  // R06: sync edge from routed input, R10 keeps it rare
  assign syncRise = tickDQ && condS[syncSelQ] && !syncPrevQ;
  // R13: fixed slew rate, zero or two ms on every tenth tick
  assign slewAct = tickQ && (slewRemQ != '0)
                   && (slewDivQ == 4'(SLEW_DIV_MS - 1));
  assign incr = slewAct ? (slewFastQ ? 2'h2 : 2'h0) : 2'h1;

  assign acc    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrEn   = acc && wb_we_i;
  assign timeWr = wrEn && (wb_adr_i == ADR_TIME);

  // Ms divider; R02: a time load realigns the ms phase
  always_ff @(posedge sys_clk) begin
    if (!nrst || timeWr) begin
      divQ  <= '0;
      tickQ <= 1'b0;
    end else begin
      tickQ <= divQ == DIV_W'(CYC_PER_MS - 1);
      divQ  <= (divQ == DIV_W'(CYC_PER_MS - 1)) ? '0 : divQ + DIV_W'(1);
    end
  end

  // Samples settle one cycle after the tick
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tickDQ <= 1'b0;
    end else begin
      tickDQ <= tickQ;
    end
  end

  // Real-time clock
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      msQ  <= '0;
      minQ <= '0;
    // R02: load from external time source
    end else if (timeWr) begin
      {minQ, msQ} <= STAMP_W'(merge({5'h00, minQ, msQ}, wb_dat_i,
                                    wb_sel_i));
    // R07: step to the nearest minute
    end else if (syncRise && inWin && !ctrlQ[CTRL_SLEW_BIT]) begin
      if (roundUp) begin
        {minQ, msQ} <= advance(minQ, MS_W'(MS_PER_MIN - 1), 2'h1);
      end else begin
        msQ <= '0;
      end
    end else if (tickQ) begin
      {minQ, msQ} <= advance(minQ, msQ, incr);
    end
  end

  // R09: gradual correction of a small offset
  always_ff @(posedge sys_clk) begin
    if (!nrst || timeWr) begin
      slewRemQ  <= '0;
      slewFastQ <= 1'b0;
      slewDivQ  <= '0;
    end else if (syncRise && inWin && ctrlQ[CTRL_SLEW_BIT]) begin
      slewRemQ  <= errMs[11:0];
      slewFastQ <= roundUp;
      slewDivQ  <= '0;
    end else if (tickQ && slewRemQ != '0) begin
      slewDivQ <= slewAct ? '0 : slewDivQ + 4'h1;
      if (slewAct) slewRemQ <= slewRemQ - 12'h001;
    end
  end

  // R01: stamp of each sampling instant
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stampQ <= '0;
    end else if (tickQ) begin
      stampQ <= {minQ, msQ};
    end
  end

  // Previous levels for change detection
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sampPrevQ <= '0;
      fltPrevQ  <= '0;
      syncPrevQ <= 1'b0;
    end else if (tickDQ) begin
      sampPrevQ <= sampS;
      fltPrevQ  <= filtS;
      syncPrevQ <= condS[syncSelQ];
    end
  end

  // R04: unfiltered event first, filtered one cycle later
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      evValid    <= 1'b0;
      evFiltered <= 1'b0;
      evMask     <= '0;
      evState    <= '0;
      evStamp    <= '0;
      fltPendQ   <= 1'b0;
      fltChgQ    <= '0;
      fltStateQ  <= '0;
      fltStampQ  <= '0;
    end else if (tickDQ) begin
      evValid    <= unfChg != '0;
      evFiltered <= 1'b0;
      evMask     <= unfChg;
      evState    <= sampS;
      // R03: unfiltered stamp is this sampling instant
      evStamp    <= stampQ;
      fltPendQ   <= fltChg != '0;
      fltChgQ    <= fltChg;
      fltStateQ  <= filtS;
      // R03: filtered stamp is the first differing sample
      fltStampQ  <= retreat(stampQ, MS_W'(FILT_MS - 1));
    end else begin
      evValid    <= fltPendQ;
      evFiltered <= fltPendQ;
      if (fltPendQ) begin
        evMask  <= fltChgQ;
        evState <= fltStateQ;
        evStamp <= fltStampQ;
      end
      fltPendQ <= 1'b0;
    end
  end

  // R05: time-driven publication of input states
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pubCntQ  <= '0;
      pubValid <= 1'b0;
      pubState <= '0;
    end else begin
      pubValid <= 1'b0;
      if (tickDQ) begin
        if (pubCntQ == 7'(PUB_MS - 1)) begin
          pubCntQ  <= '0;
          pubValid <= 1'b1;
          pubState <= condS;
        end else begin
          pubCntQ <= pubCntQ + 7'h01;
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrlQ    <= CTRL_RST;
      filtEnQ  <= FILTEN_RST[NIN-1:0];
      evMaskQ  <= EVMASK_RST[NIN-1:0];
      syncSelQ <= SEL_RST[SEL_W-1:0];
      imaskQ   <= IMASK_RST;
    end else if (wrEn) begin
      case (wb_adr_i)
        ADR_CTRL: ctrlQ <= merge(ctrlQ, wb_dat_i, wb_sel_i) & CTRL_RST;
        ADR_FILTEN: filtEnQ <= NIN'(merge(32'(filtEnQ), wb_dat_i,
                                          wb_sel_i));
        ADR_EVMASK: evMaskQ <= NIN'(merge(32'(evMaskQ), wb_dat_i,
                                          wb_sel_i));
        ADR_SYNC: if (wb_sel_i[0]) syncSelQ <= wb_dat_i[SEL_W-1:0];
        ADR_IMASK: if (wb_sel_i[0]) imaskQ <= wb_dat_i[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status, read clears, a new event wins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      statusQ <= '0;
    end else begin
      statusQ <= ((acc && !wb_we_i && wb_adr_i == ADR_STATUS)
                  ? '0 : statusQ)
        | (ST_W'(tickDQ && unfChg != '0) << ST_UNF)
        | (ST_W'(!tickDQ && fltPendQ) << ST_FLT)
        | (ST_W'(syncRise && inWin && !ctrlQ[CTRL_SLEW_BIT]) << ST_STEP)
        | (ST_W'(syncRise && inWin && ctrlQ[CTRL_SLEW_BIT]) << ST_SLEW)
        | (ST_W'(syncRise && !inWin) << ST_REJ);
    end
  end

  // Level interrupt from unmasked flags
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(statusQ & imaskQ);
    end
  end

  // Wishbone slave: ack one cycle after strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        case (wb_adr_i)
          ADR_CTRL:   wb_dat_o <= ctrlQ;
          ADR_FILTEN: wb_dat_o <= 32'(filtEnQ);
          ADR_EVMASK: wb_dat_o <= 32'(evMaskQ);
          ADR_SYNC:   wb_dat_o <= (32'(SYNC_SIG_ID) << SYNC_ID_LSB)
                                  | 32'(syncSelQ);
          ADR_TIME:   wb_dat_o <= 32'({minQ, msQ});
          ADR_STATUS: wb_dat_o <= 32'(statusQ);
          ADR_IMASK:  wb_dat_o <= 32'(imaskQ);
          ADR_INPUTS: wb_dat_o <= 32'(condS);
          default:    wb_dat_o <= '0;
        endcase
      end
    end
  end

  ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  stamp_instant_a: assert property ( // R01
    @(posedge sys_clk) disable iff (!nrst)
    tickQ && !timeWr |=> stampQ == $past({minQ, msQ}))
    else $error("stamp is not the sampling instant");

  filt_stamp_a: assert property ( // R03
    @(posedge sys_clk) disable iff (!nrst)
    tickDQ && fltChg != '0 |=> ##1 evValid && evFiltered
      && evStamp == retreat($past(stampQ, 2), MS_W'(FILT_MS - 1)))
    else $error("filtered event stamp wrong");

  unf_first_a: assert property ( // R04
    @(posedge sys_clk) disable iff (!nrst)
    tickDQ && unfChg != '0 && fltChg != '0
      |=> evValid && !evFiltered ##1 evValid && evFiltered)
    else $error("event order wrong");

  pub_now_a: assert property ( // R05
    @(posedge sys_clk) disable iff (!nrst)
    pubValid |-> pubState == $past(condS))
    else $error("publication delayed");

  step_down_a: assert property ( // R07
    @(posedge sys_clk) disable iff (!nrst)
    syncRise && inWin && !ctrlQ[CTRL_SLEW_BIT] && !roundUp && !timeWr
      |=> msQ == '0 && minQ == $past(minQ))
    else $error("round down failed");

  step_up_a: assert property ( // R08
    @(posedge sys_clk) disable iff (!nrst)
    syncRise && inWin && !ctrlQ[CTRL_SLEW_BIT] && roundUp && !timeWr
      |=> msQ == '0 && minQ != $past(minQ))
    else $error("round up failed");

  slew_load_a: assert property ( // R09
    @(posedge sys_clk) disable iff (!nrst)
    syncRise && inWin && ctrlQ[CTRL_SLEW_BIT] && !timeWr
      |=> slewRemQ == $past(errMs[11:0]) && slewFastQ == $past(roundUp))
    else $error("slew not started");

  ev_masked_a: assert property ( // R11
    @(posedge sys_clk) disable iff (!nrst)
    tickDQ |=> !evValid || (evMask & ~$past(evMaskQ)) == '0)
    else $error("masked input logged");

  no_back_a: assert property ( // R13
    @(posedge sys_clk) disable iff (!nrst)
    tickQ && !timeWr
      |=> minQ != $past(minQ) || (msQ >= $past(msQ)
          && msQ <= $past(msQ) + MS_W'(2)))
    else $error("clock went back or jumped");
endmodule

/* sync_pulse_source.sv */
module sync_pulse_source #(
  parameter int CYC_MS   = 10,
  parameter int PULSE_MS = 20
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic fire,
  output logic      syncLine
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cycles still to hold the pulse
  int pulseLeft_q;

  // One fixed pulse per request, idle low while de-energised.
  // The bench spaces requests, so retriggers inside a pulse are dropped.
  // twenty ms pulse
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pulseLeft_q <= 0;
      syncLine    <= 1'b0;
    end else if (fire && pulseLeft_q == 0) begin
      pulseLeft_q <= PULSE_MS * CYC_MS - 1;
      syncLine    <= 1'b1;
    end else if (pulseLeft_q != 0) begin
      pulseLeft_q <= pulseLeft_q - 1;
    end else begin
      syncLine <= 1'b0;
    end
  end
endmodule

/* tb_rtc_timestamp_sync.sv */
module tb_rtc_timestamp_sync;
  timeunit 1ns;
  timeprecision 1ns;
  import rtc_sync_pkg::*;
  // Short ms so the run stays brief
  localparam int CYC   = 10;
  localparam int LIMIT = 40000;
  typedef struct {logic filt; logic [15:0] mask; int ms;
                  logic [15:0] st;} evNote_t;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        wbCyc   = 1'b0;
  logic        wbStb   = 1'b0;
  logic        wbWe    = 1'b0;
  logic [3:0]  wbSel   = 4'h0;
  logic [7:0]  wbAdr   = 8'h00;
  logic [31:0] wbDat   = 32'h0000_0000;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic [15:0] pins    = 16'h0000;
  logic        fire    = 1'b0;
  logic        syncLine;
  logic        irq, evValid, evFiltered, pubValid;
  logic [15:0] evMask, evState, pubState;
  logic [26:0] evStamp;
  int          errCount, numChecks, cycle, pubCnt, sCh;
  evNote_t     expQ[$];
  evNote_t     note;
  // Reset value table, last entry unmapped
  logic [7:0]  adrT[6] = '{ADR_CTRL, ADR_FILTEN, ADR_EVMASK, ADR_SYNC,
                           ADR_IMASK, 8'h20};
  logic [31:0] rstT[6] = '{CTRL_RST, FILTEN_RST, EVMASK_RST,
                           {SYNC_SIG_ID, 24'h0}, {27'h0, IMASK_RST}, 0};
  // Sync cases: ctrl, written ms, minute, base, window, status bit
  int ctlT[4] = '{0, 0, 0, 1};
  int msT[4]  = '{59000, 2000, 20000, 58000};
  int minT[4] = '{6, 5, 5, 5};
  int bseT[4] = '{0, 0, 20000, 58000};
  int loT[4]  = '{-5, -5, -1, 6};
  int hiT[4]  = '{0, 0, 1, 13};
  int bitT[4] = '{ST_STEP, ST_STEP, ST_REJ, ST_SLEW};

  // Clock
  always #50 sys_clk = ~sys_clk;

  rtc_timestamp_sync #(.CYC_PER_MS(CYC), .NIN(16)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .optoPin(pins | (16'(syncLine) << sCh)),
    .irq(irq), .evValid(evValid), .evFiltered(evFiltered),
    .evMask(evMask), .evState(evState), .evStamp(evStamp),
    .pubValid(pubValid), .pubState(pubState));

  sync_pulse_source #(.CYC_MS(CYC), .PULSE_MS(20)) u_src (
    .sys_clk(sys_clk), .nrst(nrst), .fire(fire), .syncLine(syncLine));

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= s;
    do @(posedge sys_clk); while (wbAck !== 1'b1);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    logic [31:0] x;
    wb(1'b1, a, d, s, x);
  endtask

  // Timeout and cycle count
  always @(posedge sys_clk) begin
    cycle <= cycle + 1;
    if (cycle == LIMIT) begin
      errCount++;
      complete_run();
    end
  end

  // Event scoreboard and publication count
  always @(posedge sys_clk) begin
    if (nrst && evValid) begin
      if (expQ.size() == 0) check("evExtra", 1, 0);
      else begin
        note = expQ.pop_front();
        check("evFiltered", evFiltered, note.filt);
        check("evMask", evMask, note.mask);
        check("evState", evState, note.st);
        check("evStamp", int'(evStamp[15:0]) - note.ms inside {[-1:2]},
              1);
      end
    end
    if (nrst && pubValid) pubCnt++;
  end

  initial begin
    logic [31:0] r;
    int uCh, fCh, tWr, p0, d;
    logic [15:0] uM, fM;
    void'($urandom(79489));
    uCh = $urandom % 14;
    fCh = uCh + 1;
    sCh = uCh + 2;
    uM  = 16'h1 << uCh;
    fM  = 16'h1 << fCh;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values, unmapped write ignored
    wr(8'h20, 32'hFFFF_FFFF);
    foreach (adrT[i]) begin
      wb(1'b0, adrT[i], 0, 4'hF, r);
      check("resetVal", r, rstT[i]);
    end
    wr(ADR_FILTEN, 32'h0000_0000, 4'h1);
    wb(1'b0, ADR_FILTEN, 0, 4'hF, r);
    check("filtLane", r, 32'h0000_FF00);
    wr(ADR_FILTEN, 32'(16'hFFFF & ~(16'h1 << uCh) & ~(16'h1 << sCh)));
    wr(ADR_EVMASK, 32'(16'hFFFF & ~(16'h1 << sCh)));
    wr(ADR_TIME, {5'h0, 11'd1, 16'h0000});
    tWr = cycle;
    repeat (3 * CYC + 3) @(negedge sys_clk);
    p0 = pubCnt;
    @(posedge sys_clk);
    pins <= uM | fM;
    d = (cycle - tWr) / CYC;
    // Unfiltered input falls in the sample where the filter accepts
    expQ.push_back('{1'b0, uM, d, uM | fM});
    expQ.push_back('{1'b0, uM, d + FILT_MS - 1, fM});
    expQ.push_back('{1'b1, fM, d, fM});
    repeat ((FILT_MS - 1) * CYC) @(posedge sys_clk);
    pins <= fM;
    repeat ((301 - FILT_MS) * CYC) @(negedge sys_clk);
    check("pubCount", pubCnt - p0, 3);
    check("pubState", pubState, 32'(fM));
    check("evLeft", expQ.size(), 0);
    wb(1'b0, ADR_INPUTS, 0, 4'hF, r);
    check("inputs", r, 32'(fM));
    // Interrupt masked, unmasked, cleared by read
    wr(ADR_IMASK, 0);
    repeat (3) @(posedge sys_clk);
    check("irqMasked", irq, 0);
    wr(ADR_IMASK, 3);
    repeat (3) @(posedge sys_clk);
    check("irqSet", irq, 1);
    wb(1'b0, ADR_STATUS, 0, 4'hF, r);
    check("stEvents", r[1:0], 2'b11);
    wb(1'b0, ADR_STATUS, 0, 4'hF, r);
    check("stCleared", r[1:0], 2'b00);
    repeat (3) @(posedge sys_clk);
    check("irqClear", irq, 0);
    wr(ADR_SYNC, 32'(sCh));
    foreach (ctlT[i]) begin
      wr(ADR_CTRL, 32'(ctlT[i]));
      wr(ADR_TIME, {5'h0, 11'd5, 16'(msT[i])});
      tWr = cycle;
      wb(1'b0, ADR_STATUS, 0, 4'hF, r);
      @(posedge sys_clk);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (100 * CYC) @(posedge sys_clk);
      wb(1'b0, ADR_STATUS, 0, 4'hF, r);
      check("syncStatus", r[bitT[i]], 1);
      wb(1'b0, ADR_TIME, 0, 4'hF, r);
      d = int'(r[15:0]) - bseT[i] - (cycle - tWr) / CYC;
      check("syncMinute", r[26:16], 11'(minT[i]));
      check("syncMs", d inside {[loT[i]:hiT[i]]}, 1);
    end
    check("evLeft", expQ.size(), 0);
    complete_run();
  end
endmodule
